// ### pfc_bus_cycle.sv
// Purpose: one read or write cycle on the flash pins per start pulse
// Assumes: start only while idle; dqIn comes from the pin, unsynchronised
// Notes:   address settles one cycle before any strobe falls
`timescale 1ns/10ps
module pfc_bus_cycle
  import pfc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic              isWrite,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic                   done,
  output logic      [DATA_W-1:0] rdData,
  output logic      [ADDR_W-1:0] flashAddr,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN,
  output logic      [DATA_W-1:0] dqOut,
  output logic                   dqOe,
  input  wire logic [DATA_W-1:0] dqIn
);

  pfc_bus_state_type stReg, stNext;
  logic [7:0]        cntReg, cntNext;
  logic              wrReg, wrNext;
  logic [ADDR_W-1:0] addrNext;
  logic              ceNNext, oeNNext, weNNext, dqOeNext, doneNext;
  logic [DATA_W-1:0] dqOutNext, rdNext;
  logic [DATA_W-1:0] dqMetaReg, dqSyncReg;

  ////////////////////////////////////////////////////////////////////////
  // next pin state; address before strobes, data held past the rising edge
  always_comb begin
    stNext    = stReg;
    cntNext   = cntReg;
    wrNext    = wrReg;
    addrNext  = flashAddr;
    ceNNext   = flashCeN;
    oeNNext   = flashOeN;
    weNNext   = flashWeN;
    dqOutNext = dqOut;
    dqOeNext  = dqOe;
    rdNext    = rdData;
    doneNext  = 1'b0;
    unique case (stReg)
      BS_IDLE: begin
        if (start) begin
          wrNext    = isWrite;
          addrNext  = addrIn;
          dqOutNext = dataIn;
          ceNNext   = 1'b0;
          dqOeNext  = isWrite;
          stNext    = BS_SETUP;
        end
      end
      BS_SETUP: begin
        stNext = BS_STROBE;
        if (wrReg) begin
          weNNext = 1'b0; // write strobe only under chip select
          cntNext = WP_CYC - 8'h01;
        end else begin
          oeNNext = 1'b0;
          cntNext = READ_CYC - 8'h01;
        end
      end
      BS_STROBE: begin
        if (cntReg != 8'h00) begin
          cntNext = cntReg - 8'h01;
        end else begin
          if (!wrReg) begin
            rdNext = dqSyncReg;
          end
          ceNNext = 1'b1;
          oeNNext = 1'b1;
          weNNext = 1'b1;
          cntNext = HOLD_CYC - 8'h01;
          stNext  = BS_HOLD;
        end
      end
      BS_HOLD: begin
        if (cntReg != 8'h00) begin
          cntNext = cntReg - 8'h01;
        end else begin
          dqOeNext = 1'b0;
          doneNext = 1'b1;
          stNext   = BS_IDLE;
        end
      end
    endcase
  end

  // all pins from flops; dq input through two flops first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stReg     <= BS_IDLE;
      cntReg    <= 8'h00;
      wrReg     <= 1'b0;
      flashAddr <= '0;
      flashCeN  <= 1'b1;
      flashOeN  <= 1'b1;
      flashWeN  <= 1'b1;
      dqOut     <= '0;
      dqOe      <= 1'b0;
      rdData    <= '0;
      done      <= 1'b0;
      dqMetaReg <= '0;
      dqSyncReg <= '0;
    end else begin
      stReg     <= stNext;
      cntReg    <= cntNext;
      wrReg     <= wrNext;
      flashAddr <= addrNext;
      flashCeN  <= ceNNext;
      flashOeN  <= oeNNext;
      flashWeN  <= weNNext;
      dqOut     <= dqOutNext;
      dqOe      <= dqOeNext;
      rdData    <= rdNext;
      done      <= doneNext;
      dqMetaReg <= dqIn;
      dqSyncReg <= dqMetaReg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on the pin protocol
  property p_we_in_cs;
    @(posedge sys_clk) disable iff (!rst_n) !flashWeN |-> (!flashCeN && flashOeN && dqOe);
  endproperty
  a_we_in_cs: assert property (p_we_in_cs) else $error("write strobe low outside chip select");

  property p_addr_before_we;
    @(posedge sys_clk) disable iff (!rst_n) $fell(flashWeN) |-> $stable(flashAddr) && $past(!flashCeN);
  endproperty
  a_addr_before_we: assert property (p_addr_before_we) else $error("address moved as write strobe fell");

  property p_data_held;
    @(posedge sys_clk) disable iff (!rst_n) $rose(flashWeN) |-> dqOe && $stable(dqOut);
  endproperty
  a_data_held: assert property (p_data_held) else $error("data not held at write strobe rise");

endmodule

// ### pfc_flash_host.sv
// Purpose: host sequencer that drives command, erase, program and lock
//          sequences onto a byte-wide parallel flash
// Assumes: one command at a time on the cmd port; device obeys its own rules
// Notes:   completion is found by toggle-bit polling
`timescale 1ns/10ps
module pfc_flash_host
  import pfc_pkg::*;
#(
  parameter int PROG_LIMIT   = PROG_MAX_CYC,
  parameter int SECTOR_LIMIT = SECTOR_MAX_CYC,
  parameter int CHIP_LIMIT   = CHIP_MAX_CYC
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              cmdValid,
  input  wire logic [2:0]        cmdOp,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdData,
  output logic                   cmdReady,
  output logic                   rspValid,
  output logic      [DATA_W-1:0] rspData,
  output logic                   rspError,
  output logic                   writeLocked,
  output logic      [ADDR_W-1:0] flashAddr,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN,
  output logic      [DATA_W-1:0] dqOut,
  output logic                   dqOe,
  input  wire logic [DATA_W-1:0] dqIn
);

  if (PROG_LIMIT < 1 || SECTOR_LIMIT < 1 || CHIP_LIMIT < 1 ||
      CHIP_LIMIT >= 2**LIM_W || SECTOR_LIMIT >= 2**LIM_W || PROG_LIMIT >= 2**LIM_W) begin : g_chk
    $error("operation limits must lie between 1 and the counter range");
  end

  pfc_state_type     stateReg, stateNext;
  pfc_op_type        opReg, opNext;
  logic [ADDR_W-1:0] addrReg, addrNext;
  logic [DATA_W-1:0] dataReg, dataNext;
  logic [2:0]        stepReg, stepNext;
  logic              pollHaveReg, pollHaveNext, pollPrevReg, pollPrevNext;
  logic [LIM_W-1:0]  limCntReg, limCntNext, limSel;
  logic              startReg, startNext, busWrReg, busWrNext;
  logic [ADDR_W-1:0] busAddrReg, busAddrNext;
  logic [DATA_W-1:0] busDataReg, busDataNext;
  logic              readyNext, rspValidNext, rspErrorNext, lockNext;
  logic [DATA_W-1:0] rspDataNext;
  pfc_kind_type      stepKind;
  logic [ADDR_W-1:0] stepAddr;
  logic [DATA_W-1:0] stepData;
  logic              busDone;
  logic [DATA_W-1:0] busRd;

  ////////////////////////////////////////////////////////////////////////
  // one pin cycle at a time; the cycle engine owns the pins
  pfc_bus_cycle u_bus (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .start     (startReg),
    .isWrite   (busWrReg),
    .addrIn    (busAddrReg),
    .dataIn    (busDataReg),
    .done      (busDone),
    .rdData    (busRd),
    .flashAddr (flashAddr),
    .flashCeN  (flashCeN),
    .flashOeN  (flashOeN),
    .flashWeN  (flashWeN),
    .dqOut     (dqOut),
    .dqOe      (dqOe),
    .dqIn      (dqIn)
  );

  ////////////////////////////////////////////////////////////////////////
  // step table: what pin cycle each step of each operation performs
  always_comb begin
    stepKind = K_END;
    stepAddr = addrReg;
    stepData = CMD_RESET;
    unique case (opReg)
      OP_READ: begin
        if (stepReg == 3'h0) stepKind = K_RD;
      end
      OP_PROGRAM: begin
        if (stepReg == 3'h0) begin
          stepKind = K_WR; // setup, then the next write is the program cycle
          stepData = CMD_PROGRAM;
        end else if (stepReg == 3'h1) begin
          stepKind = K_WR;
          stepData = dataReg;
        end else if (stepReg == 3'h2) begin
          stepKind = K_POLL;
        end
      end
      OP_SECTOR_ERASE: begin
        if (stepReg == 3'h0) begin
          stepKind = K_WR;
          stepData = CMD_SECTOR_SETUP;
        end else if (stepReg == 3'h1) begin
          stepKind = K_WR;
          stepData = CMD_SECTOR_EXEC;
        end else if (stepReg == 3'h2) begin
          stepKind = K_POLL;
        end
      end
      OP_CHIP_ERASE: begin
        if (stepReg <= 3'h1) begin
          stepKind = K_WR; // setup and execute are the same byte
          stepData = CMD_CHIP;
        end else if (stepReg == 3'h2) begin
          stepKind = K_POLL;
        end
      end
      OP_READ_ID: begin
        if (stepReg == 3'h0) begin
          stepKind = K_WR;
          stepData = CMD_READ_ID;
        end else if (stepReg == 3'h1) begin
          stepKind = K_RD;
        end else if (stepReg == 3'h2) begin
          stepKind = K_WR; // leave id mode so plain reads see the array
        end
      end
      OP_UNLOCK, OP_LOCK: begin
        if (stepReg != 3'h7) begin
          stepKind = K_RD; // seven reads at fixed addresses
          stepAddr = UNLOCK_SEQ[stepReg];
          if (opReg == OP_LOCK && stepReg == 3'h6) stepAddr = LOCK_LAST_ADDR;
        end
      end
      OP_ABORT: begin
        if (stepReg == 3'h0) stepKind = K_WR;
      end
    endcase
  end

  // timeout limit for the running operation
  always_comb begin
    limSel = LIM_W'(PROG_LIMIT);
    if (opReg == OP_SECTOR_ERASE) limSel = LIM_W'(SECTOR_LIMIT);
    if (opReg == OP_CHIP_ERASE) limSel = LIM_W'(CHIP_LIMIT);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: accept, walk the steps, poll, answer
  always_comb begin
    stateNext    = stateReg;
    opNext       = opReg;
    addrNext     = addrReg;
    dataNext     = dataReg;
    stepNext     = stepReg;
    pollHaveNext = pollHaveReg;
    pollPrevNext = pollPrevReg;
    limCntNext   = limCntReg;
    startNext    = 1'b0;
    busWrNext    = busWrReg;
    busAddrNext  = busAddrReg;
    busDataNext  = busDataReg;
    readyNext    = cmdReady;
    rspValidNext = 1'b0;
    rspDataNext  = rspData;
    rspErrorNext = rspError;
    lockNext     = writeLocked;
    unique case (stateReg)
      ST_IDLE: begin
        if (cmdValid) begin
          opNext       = pfc_op_type'(cmdOp);
          addrNext     = cmdAddr;
          dataNext     = cmdData;
          stepNext     = 3'h0;
          pollHaveNext = 1'b0;
          limCntNext   = '0;
          readyNext    = 1'b0;
          stateNext    = ST_ISSUE;
          // a reissued erase is served like any other
          if (writeLocked && (cmdOp == OP_PROGRAM || cmdOp == OP_SECTOR_ERASE ||
                              cmdOp == OP_CHIP_ERASE)) begin
            rspValidNext = 1'b1; // the device would ignore it while locked
            rspErrorNext = 1'b1;
            readyNext    = 1'b1;
            stateNext    = ST_IDLE;
          end
        end
      end
      ST_ISSUE: begin
        if (stepKind == K_END) begin
          rspValidNext = 1'b1;
          rspErrorNext = 1'b0;
          readyNext    = 1'b1;
          if (opReg == OP_UNLOCK) lockNext = 1'b0;
          if (opReg == OP_LOCK) lockNext = 1'b1;
          stateNext = ST_IDLE;
        end else begin
          startNext   = 1'b1;
          busWrNext   = (stepKind == K_WR);
          busAddrNext = stepAddr;
          busDataNext = stepData;
          stateNext   = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (stepKind == K_POLL && limCntReg != limSel) begin
          limCntNext = limCntReg + 1'b1;
        end
        if (busDone) begin
          stateNext = ST_ISSUE;
          if (stepKind != K_WR) rspDataNext = busRd;
          if (stepKind != K_POLL) begin
            stepNext = stepReg + 3'h1;
          end else if (pollHaveReg && busRd[TOGGLE_BIT] == pollPrevReg) begin
            stepNext = stepReg + 3'h1; // toggling stopped, write finished
          end else if (limCntReg == limSel) begin
            rspValidNext = 1'b1; // overran the longest time; a reissue may finish it
            rspErrorNext = 1'b1;
            readyNext    = 1'b1;
            stateNext    = ST_IDLE;
          end else begin
            pollHaveNext = 1'b1;
            pollPrevNext = busRd[TOGGLE_BIT];
          end
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  // state registers; lock assumed set after reset like the device
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg    <= ST_IDLE;
      opReg       <= OP_READ;
      addrReg     <= '0;
      dataReg     <= '0;
      stepReg     <= 3'h0;
      pollHaveReg <= 1'b0;
      pollPrevReg <= 1'b0;
      limCntReg   <= '0;
      startReg    <= 1'b0;
      busWrReg    <= 1'b0;
      busAddrReg  <= '0;
      busDataReg  <= '0;
      cmdReady    <= 1'b1;
      rspValid    <= 1'b0;
      rspData     <= '0;
      rspError    <= 1'b0;
      writeLocked <= 1'b1;
    end else begin
      stateReg    <= stateNext;
      opReg       <= opNext;
      addrReg     <= addrNext;
      dataReg     <= dataNext;
      stepReg     <= stepNext;
      pollHaveReg <= pollHaveNext;
      pollPrevReg <= pollPrevNext;
      limCntReg   <= limCntNext;
      startReg    <= startNext;
      busWrReg    <= busWrNext;
      busAddrReg  <= busAddrNext;
      busDataReg  <= busDataNext;
      cmdReady    <= readyNext;
      rspValid    <= rspValidNext;
      rspData     <= rspDataNext;
      rspError    <= rspErrorNext;
      writeLocked <= lockNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helper history for checks: last byte written, reads in this command
  logic [DATA_W-1:0] prevWrReg;
  logic [2:0]        readCntReg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevWrReg  <= 8'h00;
      readCntReg <= 3'h0;
    end else begin
      if (startReg && busWrReg) prevWrReg <= busDataReg;
      if (stateReg == ST_IDLE) readCntReg <= 3'h0;
      else if (startReg && !busWrReg) readCntReg <= readCntReg + 3'h1;
    end
  end

  property p_sector_pair;
    @(posedge sys_clk) disable iff (!rst_n)
      (startReg && busWrReg && opReg == OP_SECTOR_ERASE && busDataReg == CMD_SECTOR_EXEC)
      |-> prevWrReg == CMD_SECTOR_SETUP && busAddrReg == addrReg;
  endproperty
  a_sector_pair: assert property (p_sector_pair) else $error("sector execute not after setup");

  property p_chip_pair;
    @(posedge sys_clk) disable iff (!rst_n)
      (startReg && busWrReg && opReg == OP_CHIP_ERASE && stepReg == 3'h1)
      |-> prevWrReg == CMD_CHIP && busDataReg == CMD_CHIP;
  endproperty
  a_chip_pair: assert property (p_chip_pair) else $error("chip erase bytes wrong");

  property p_program_pair;
    @(posedge sys_clk) disable iff (!rst_n)
      (startReg && busWrReg && opReg == OP_PROGRAM && stepReg == 3'h1)
      |-> prevWrReg == CMD_PROGRAM && busDataReg == dataReg ##1 !flashCeN;
  endproperty
  a_program_pair: assert property (p_program_pair) else $error("program cycle not after setup");

  property p_unlock_reads;
    @(posedge sys_clk) disable iff (!rst_n)
      (rspValid && !rspError && (opReg == OP_UNLOCK || opReg == OP_LOCK))
      |-> readCntReg == 3'h7 && writeLocked == (opReg == OP_LOCK);
  endproperty
  a_unlock_reads: assert property (p_unlock_reads) else $error("lock sequence not seven reads");

  property p_lock_last;
    @(posedge sys_clk) disable iff (!rst_n)
      (startReg && opReg == OP_LOCK && stepReg == 3'h6)
      |-> !busWrReg && busAddrReg == LOCK_LAST_ADDR;
  endproperty
  a_lock_last: assert property (p_lock_last) else $error("lock sequence last address wrong");

endmodule

// ### pfc_flash_model.sv
// Purpose: behavioural byte-wide flash seen at the host controller pins
// Assumes: one operation at a time; BUSY_NS stands in for the internal timer
// Notes:   identity values are arbitrary; cells are modelled sparsely
`timescale 1ns/10ps
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int         BUSY_NS  = 3000,
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'hA5  // arbitrary value
)(
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic              flashCeN,
  input  wire logic              flashOeN,
  input  wire logic              flashWeN,
  input  wire logic [DATA_W-1:0] dqBus,
  output logic      [DATA_W-1:0] dqDrv,
  output logic                   dqEn
);
  localparam logic [18:0] SEQ [6] = '{19'h01823, 19'h01820, 19'h01822, 19'h00418, 19'h0041B, 19'h00419};
  logic [7:0]  mem [int];
  logic [7:0]  setupReg = 8'h00;
  logic [7:0]  pendReg  = 8'hFF;
  logic [18:0] wAddr, pAddr;
  logic        locked   = 1'b1; // power-up locked, read mode
  logic        idMode   = 1'b0;
  logic        busy     = 1'b0;
  logic        tog      = 1'b0;
  int          seqIdx   = 0;
  wire         wrAct    = ~flashWeN & ~flashCeN;
  wire         rdAct    = ~flashOeN & ~flashCeN & flashWeN;

  ////////////////////////////////////////////////////////////////////////
  // data lines float unless selected with output gated
  assign dqEn = rdAct;
  always @* begin
    if (busy) dqDrv = {~pendReg[7], tog, pendReg[5:0]};
    else if (idMode) dqDrv = (flashAddr == 19'h0) ? MAKER_ID : (flashAddr == 19'h1) ? PART_ID : 8'hFF;
    else dqDrv = mem.exists(int'(flashAddr)) ? mem[int'(flashAddr)] : 8'hFF; // erased reads FFH
  end

  // address taken at the earlier rise of OE or CE; any dq state is fine
  always @(negedge rdAct) begin
    if (busy) tog = ~tog;
    if (seqIdx == 6 && flashAddr == 19'h0041A) locked = 1'b0;
    if (seqIdx == 6 && flashAddr == 19'h0040A) locked = 1'b1;
    seqIdx = (seqIdx < 6 && flashAddr == SEQ[seqIdx]) ? seqIdx + 1 : ((flashAddr == SEQ[0]) ? 1 : 0);
  end

  ////////////////////////////////////////////////////////////////////////
  // own timer; well inside the longest times, so no early cut applies
  task automatic run_op(input logic [7:0] code);
    logic [18:0] a;
    logic [7:0]  d;
    a = pAddr;
    d = pendReg;
    busy = 1'b1;
    if (code != 8'h10) pendReg = 8'hFF;
    fork
      begin
        #(BUSY_NS);
        if (code == 8'h10) mem[int'(a)] = d; // only the addressed byte
        else if (code == 8'h30) mem.delete();
        else for (int i = 0; i < 256; i++) mem.delete(int'({a[18:8], 8'(i)})); // re-erase harmless
        busy = 1'b0;
      end
    join_none
  endtask

  // address at the later fall, data at the earlier rise of WE or CE
  always @(posedge wrAct) wAddr = flashAddr;
  always @(negedge wrAct) begin
    if (!busy) begin // writes ignored while running
      pAddr = wAddr;
      pendReg = dqBus;
      if (setupReg == 8'h10 || (setupReg == 8'h20 && dqBus == 8'hD0) || (setupReg == 8'h30 && dqBus == 8'h30))
        run_op(setupReg);
      else if (dqBus == 8'hFF) idMode = 1'b0; // memory and lock left alone
      else if (dqBus == 8'h90) idMode = 1'b1;
      // setups are refused while locked
      setupReg = (!locked && setupReg == 8'h00 && dqBus inside {8'h10, 8'h20, 8'h30}) ? dqBus : 8'h00;
    end
  end
endmodule

// ### pfc_pkg.sv
// Purpose: shared constants and types for the parallel flash host controller
// Assumes: 100 MHz sys_clk, byte-wide flash with 19 address lines
// Notes:   strobe timings are kept generous so that slow parts are served too
package pfc_pkg;

  localparam int ADDR_W    = 19;
  localparam int DATA_W    = 8;
  localparam int PERIOD_NS = 10;

  // pin cycle timing in ns, rounded up to whole clock cycles
  localparam int T_ACC_NS  = 200;
  localparam int T_WP_NS   = 100;
  localparam int T_HOLD_NS = 50;
  localparam int SYNC_CYC  = 2;
  localparam logic [7:0] ACC_CYC  = 8'((T_ACC_NS + PERIOD_NS - 1) / PERIOD_NS);
  localparam logic [7:0] WP_CYC   = 8'((T_WP_NS + PERIOD_NS - 1) / PERIOD_NS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + PERIOD_NS - 1) / PERIOD_NS);
  localparam logic [7:0] READ_CYC = 8'(ACC_CYC + 8'(SYNC_CYC));

  // longest operation times in us; counts round down
  localparam int SECTOR_MAX_US = 4000;
  localparam int CHIP_MAX_US   = 20000;
  localparam int PROG_MAX_US   = 140;
  localparam int SECTOR_MAX_CYC = SECTOR_MAX_US * 1000 / PERIOD_NS;
  localparam int CHIP_MAX_CYC   = CHIP_MAX_US * 1000 / PERIOD_NS;
  localparam int PROG_MAX_CYC   = PROG_MAX_US * 1000 / PERIOD_NS;
  localparam int LIM_W          = 22;

  // command bytes
  localparam logic [7:0] CMD_SECTOR_SETUP = 8'h20;
  localparam logic [7:0] CMD_SECTOR_EXEC  = 8'hD0;
  localparam logic [7:0] CMD_CHIP         = 8'h30;
  localparam logic [7:0] CMD_PROGRAM      = 8'h10;
  localparam logic [7:0] CMD_RESET        = 8'hFF;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;

  // seven-read address sequence; index 0 is read first
  localparam logic [6:0][18:0] UNLOCK_SEQ = {19'h0041A, 19'h00419, 19'h0041B, 19'h00418,
                                             19'h01822, 19'h01820, 19'h01823};
  localparam logic [18:0] LOCK_LAST_ADDR = 19'h0040A;
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [2:0] {
    OP_READ         = 3'b000,
    OP_PROGRAM      = 3'b001,
    OP_SECTOR_ERASE = 3'b010,
    OP_CHIP_ERASE   = 3'b011,
    OP_READ_ID      = 3'b100,
    OP_UNLOCK       = 3'b101,
    OP_LOCK         = 3'b110,
    OP_ABORT        = 3'b111
  } pfc_op_type;

  typedef enum logic [1:0] {
    K_WR   = 2'b00,
    K_RD   = 2'b01,
    K_POLL = 2'b10,
    K_END  = 2'b11
  } pfc_kind_type;

  typedef enum logic [1:0] {
    BS_IDLE   = 2'b00,
    BS_SETUP  = 2'b01,
    BS_STROBE = 2'b10,
    BS_HOLD   = 2'b11
  } pfc_bus_state_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } pfc_state_type;

endpackage

// ### test_pfc_flash_host.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: operation limits shortened to LIM cycles, device timer 300 cycles
// Notes:   released data lines show a changing pattern, not the last value
`timescale 1ns/10ps
module test_pfc_flash_host
  import pfc_pkg::*;
;
  localparam int         LIM   = 2000;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] PART  = 8'hA5; // arbitrary value
  logic              sys_clk  = 1'b0;
  logic              rst_n    = 1'b0;
  logic              cmdValid = 1'b0;
  logic [2:0]        cmdOp    = 3'h0;
  logic [ADDR_W-1:0] cmdAddr  = 19'h0;
  logic [DATA_W-1:0] cmdData  = 8'h00;
  logic [DATA_W-1:0] noise    = 8'h00;
  logic [ADDR_W-1:0] flashAddr, a;
  logic [DATA_W-1:0] rspData, dqOut, dqDrv, d;
  logic              cmdReady, rspValid, rspError, writeLocked, flashCeN, flashOeN, flashWeN, dqOe, dqEn;
  logic [9:0]        e;
  logic [9:0]        expQ [$];
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                seed       = 16;
  wire  [DATA_W-1:0] dqBus = dqOe ? dqOut : (dqEn ? dqDrv : noise);

  pfc_flash_host #(.PROG_LIMIT(LIM), .SECTOR_LIMIT(LIM), .CHIP_LIMIT(LIM)) uut (.sys_clk(sys_clk),
    .rst_n(rst_n), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
    .writeLocked(writeLocked), .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqBus));
  pfc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash (.flashAddr(flashAddr), .flashCeN(flashCeN),
    .flashOeN(flashOeN), .flashWeN(flashWeN), .dqBus(dqBus), .dqDrv(dqDrv), .dqEn(dqEn));

  ////////////////////////////////////////////////////////////////////////
  // clock, and a floating-bus pattern that never repeats the last value
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) noise <= noise + 8'h35;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one command: note the expectation, hold the request through its take edge
  task automatic do_cmd(input logic [2:0] op, input logic [18:0] ad, input logic [7:0] dt,
                        input logic err, input logic chk, input logic [7:0] ed);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 100) n_mismatch++; // a port that never frees up is a failure
    expQ.push_back({chk, err, ed});
    cmdOp = op;
    cmdAddr = ad;
    cmdData = dt;
    cmdValid = 1'b1;
    @(posedge sys_clk);
    #1 cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 20000) n_mismatch++; // missing answer counts as a mismatch
  endtask

  ////////////////////////////////////////////////////////////////////////
  // answer watcher; also the write strobe only falls under CE with OE high
  always @(posedge sys_clk) begin
    if (rspValid === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      check("rspError", {7'h0, rspError}, {7'h0, e[8]});
      if (e[9]) check("rspData", rspData, e[7:0]);
    end
    if (rst_n && flashWeN === 1'b0) check("strobe pins", {6'h0, flashCeN, flashOeN}, 8'h01);
  end

  // watchdog, a few times the expected run and well under the cycle budget
  initial begin
    #(500_000);
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check("writeLocked", {7'h0, writeLocked}, 8'h01);
    do_cmd(OP_PROGRAM, 19'h00123, 8'h00, 1'b1, 1'b0, 8'h00);
    do_cmd(OP_READ, 19'h00123, 8'h00, 1'b0, 1'b1, 8'hFF);
    do_cmd(OP_UNLOCK, 19'h0, 8'h00, 1'b0, 1'b0, 8'h00);
    check("writeLocked", {7'h0, writeLocked}, 8'h00);
    check("device lock", {7'h0, flash.locked}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      a = 19'($random(seed));
      d = 8'($random(seed));
      do_cmd(OP_PROGRAM, a, d, 1'b0, 1'b0, 8'h00);
      do_cmd(OP_PROGRAM, a ^ 19'h00100, ~d, 1'b0, 1'b0, 8'h00);
      do_cmd(OP_READ, a, 8'h00, 1'b0, 1'b1, d);
      do_cmd(OP_READ, a ^ 19'h00001, 8'h00, 1'b0, 1'b1, 8'hFF);
      do_cmd(OP_ABORT, 19'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      do_cmd(OP_READ, a, 8'h00, 1'b0, 1'b1, d);
      repeat (2) do_cmd(OP_SECTOR_ERASE, a, 8'h00, 1'b0, 1'b0, 8'h00);
      do_cmd(OP_READ, a, 8'h00, 1'b0, 1'b1, 8'hFF);
      do_cmd(OP_READ, a ^ 19'h00100, 8'h00, 1'b0, 1'b1, ~d);
    end
    do_cmd(OP_READ_ID, 19'h0, 8'h00, 1'b0, 1'b1, MAKER);
    do_cmd(OP_READ_ID, 19'h1, 8'h00, 1'b0, 1'b1, PART);
    do_cmd(OP_READ, a ^ 19'h00100, 8'h00, 1'b0, 1'b1, ~d);
    do_cmd(OP_CHIP_ERASE, 19'h0, 8'h00, 1'b0, 1'b0, 8'h00);
    do_cmd(OP_READ, a ^ 19'h00100, 8'h00, 1'b0, 1'b1, 8'hFF);
    do_cmd(OP_LOCK, 19'h0, 8'h00, 1'b0, 1'b0, 8'h00);
    check("writeLocked", {7'h0, writeLocked}, 8'h01);
    check("device lock", {7'h0, flash.locked}, 8'h01);
    do_cmd(OP_SECTOR_ERASE, a, 8'h00, 1'b1, 1'b0, 8'h00);
    repeat (2) @(posedge sys_clk);
    // an expectation never matched by an answer is a lost response
    if (expQ.size() != 0) n_mismatch++;
    finish_test();
  end
endmodule
